// *** hdl/msc_pkg.sv ***
// Shared constants and types for the modem sample clock mode select block
package msc_pkg;

	// ==========================================================
	// Register map (byte offsets on the bus, low address byte)
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_RX_PHASE = 8'h10;
	localparam logic [7:0] OFS_TX_PHASE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// ==========================================================
	// Field positions
	localparam int CTRL0_MODE_LSB = 0;
	localparam int CTRL0_INTERP_BIT = 9;
	localparam int STAT_BUSY_BIT = 3;
	localparam int STAT_INTERP_BIT = 4;
	localparam int STAT_BADMODE_BIT = 5;
	localparam int PHASE_W = 16;
	localparam int CNT_W = 16;

	// ==========================================================
	// Values after reset
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic RST_INTERP = 1'b0;
	localparam logic [15:0] RST_PHASE = 16'h0000;

	// ==========================================================
	// Timing: system clock and default strobe rates
	localparam int CLK_HZ = 50_000_000;
	localparam int MCLK_HZ = 13_824_000;
	localparam int SAMPLE_HZ = 9600;
	localparam int BIT_HZ = 4800;
	localparam int BAUD_HZ = 2400;
	localparam int CONV_CYC = CLK_HZ / SAMPLE_HZ;
	// Bit and baud periods are whole multiples of the strobe period, so that
	// every bit and baud pulse lands on a strobe; a plain division drifts off it
	localparam int BIT_CYC = CONV_CYC * (SAMPLE_HZ / BIT_HZ);
	localparam int BAUD_CYC = CONV_CYC * (SAMPLE_HZ / BAUD_HZ);

	// ==========================================================
	// Operating modes
	typedef enum logic [2:0] {
		MODE_ASYNC_FB = 3'b000,
		MODE_V32_TERMINAL_SYNC_IN = 3'b100,
		MODE_V32_INT = 3'b101,
		MODE_V32_LOOP = 3'b110,
		MODE_ASYNC_TERMINAL_SYNC_IN = 3'b111
	} msc_mode_e;

	// Mode entry sequence, Gray coded from run through soft reset to lock
	typedef enum logic [1:0] {
		SEQ_RUN = 2'b00,
		SEQ_SRST = 2'b01,
		SEQ_LOCK = 2'b11
	} msc_seq_e;

	// ==========================================================
	// Carriers between the top and the strobe generators
	typedef struct packed {
		logic [CNT_W-1:0] conv;
		logic [CNT_W-1:0] bitc;
		logic [CNT_W-1:0] baud;
	} msc_cnt_s;

	typedef struct packed {
		logic restart;
		logic load;
		msc_cnt_s load_cnt;
		logic adj_valid;
		logic [PHASE_W-1:0] adj;
	} msc_gen_ctl_s;

	typedef struct packed {
		logic strobe;
		logic bitc;
		logic baud;
	} msc_gen_out_s;

endpackage

// *** hdl/msc_strobe_gen.sv ***
// Conversion strobe with bit and baud clocks from one aligned counter set
`timescale 1ns/100ps
module msc_strobe_gen #(
	parameter int CONV_P = msc_pkg::CONV_CYC,
	parameter int BIT_P = msc_pkg::BIT_CYC,
	parameter int BAUD_P = msc_pkg::BAUD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire msc_pkg::msc_gen_ctl_s ctl_i,
	output msc_pkg::msc_cnt_s cnt_o,
	output msc_pkg::msc_gen_out_s out_o
);

	msc_pkg::msc_cnt_s next_cnt;
	msc_pkg::msc_gen_out_s next_out;

	// One counter lane: advance, apply signed shift, wrap by one period into 0..p-1 for shifts smaller than p
	function automatic logic [15:0] step(input logic [15:0] c, input int p,
			input logic en, input logic [15:0] adj);
		logic signed [17:0] s;
		logic signed [17:0] per;
		per = $signed(18'(p));
		s = $signed({2'b00, c}) + 18'sd1;
		if (en) begin
			s = s + $signed({{2{adj[15]}}, adj});
		end
		if (s >= per) begin
			s = s - per;
		end else if (s < 18'sd0) begin
			s = s + per;
		end
		return s[15:0];
	endfunction

	// All lanes restart and shift together, so bit and baud stay on the strobe
	always_comb begin
		msc_pkg::msc_cnt_s base;
		base = ctl_i.load ? ctl_i.load_cnt : cnt_o;
		next_cnt.conv = step(base.conv, CONV_P, ctl_i.adj_valid, ctl_i.adj);
		next_cnt.bitc = step(base.bitc, BIT_P, ctl_i.adj_valid, ctl_i.adj);
		next_cnt.baud = step(base.baud, BAUD_P, ctl_i.adj_valid, ctl_i.adj);
		if (ctl_i.restart) begin
			next_cnt = '0;
		end
		next_out.strobe = (next_cnt.conv == '0);
		next_out.bitc = (next_cnt.bitc == '0);
		next_out.baud = (next_cnt.baud == '0);
	end

	// Count and pulse registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_o <= '0;
			out_o <= '0;
		end else if (ce_i) begin
			cnt_o <= next_cnt;
			out_o <= next_out;
		end
	end

endmodule

// *** hdl/msc_top.sv ***
// Mode controlled transmit/receive sample strobe and clock generation
// ==========================================================
// Notes on behaviour
// - Mode 000 free running, both phases adjustable; 111 transmit follows terminal sync.
// - 100 and 101 lock receive to transmit; 100 then tracks sync; 110 loops.
// - Async modes time receive on receive strobe; V.32 modes use transmit strobe.
// - Interpolator only in 100/101: loads on transmit strobe, outputs on receive.
// - Receive phase via register 4, transmit via 5, only where the mode allows.
// - In loopback a receive phase shift moves transmit by the same amount.
// - Receive bit and baud clocks stay synchronous to the receive strobe.
// - Transmit bit and baud clocks stay synchronous to the transmit strobe.
// - Entering 100 or 101 from an async mode soft resets before locking.
// - Interpolator runs only with control bit 9 set; follows receive phase.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module msc_top #(
	parameter int CONV_P = msc_pkg::CONV_CYC,
	parameter int BIT_P = msc_pkg::BIT_CYC,
	parameter int BAUD_P = msc_pkg::BAUD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic terminal_sync_in_i,
	output logic tx_conv_strobe_o,
	output logic rx_conv_strobe_o,
	output logic tx_bit_clock_o,
	output logic tx_baud_clock_o,
	output logic rx_bit_clock_o,
	output logic rx_baud_clock_o,
	output logic adc_conv_o,
	output logic dac_conv_o,
	output logic interp_load_o,
	output logic interp_out_o
);

	// ==========================================================
	// Bus slave state
	logic wr_pend;
	logic rd_pend;
	logic [7:0] addr_q;
	logic next_wr_pend;
	logic next_rd_pend;
	logic [7:0] next_addr_q;
	logic [31:0] next_hrdata;
	logic next_hreadyout;

	// Control state
	msc_pkg::msc_mode_e mode;
	msc_pkg::msc_seq_e seq;
	logic interp_en;
	logic bad_mode;
	logic [15:0] rx_phase;
	logic [15:0] tx_phase;
	msc_pkg::msc_mode_e next_mode;
	msc_pkg::msc_seq_e next_seq;
	logic next_interp_en;
	logic next_bad_mode;
	logic [15:0] next_rx_phase;
	logic [15:0] next_tx_phase;

	// Terminal sync synchroniser
	logic ts_meta;
	logic ts_sync;
	logic ts_prev;

	// Generators and decoded strobes
	msc_pkg::msc_gen_ctl_s tx_ctl;
	msc_pkg::msc_gen_ctl_s rx_ctl;
	msc_pkg::msc_cnt_s tx_cnt;
	msc_pkg::msc_cnt_s rx_cnt;
	msc_pkg::msc_gen_out_s tx_out;
	msc_pkg::msc_gen_out_s rx_out;

	logic wr_ctrl0;
	logic wr_rx_ph;
	logic wr_tx_ph;
	logic wr_status;
	logic [2:0] wr_code;
	logic code_ok;
	logic ts_edge;
	logic mode_async;
	logic mode_v32sync;
	logic interp_act;
	logic rx_adj_go;
	logic tx_adj_go;
	logic [31:0] rd_val;

	// ==========================================================
	// AHB-Lite slave: writes take no wait, reads take one wait state
	// so that read data always reflects a write finished just before.
	always_comb begin
		next_wr_pend = 1'b0;
		next_rd_pend = 1'b0;
		next_addr_q = addr_q;
		next_hrdata = hrdata_o;
		next_hreadyout = 1'b1;
		if (rd_pend) begin
			next_hrdata = rd_val;
		end else if (hsel_i && hready_i && htrans_i[1]) begin
			next_addr_q = haddr_i[7:0];
			next_wr_pend = hwrite_i;
			next_rd_pend = !hwrite_i;
			next_hreadyout = hwrite_i;
		end
	end

	// Register read mux; unmapped offsets read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (addr_q)
			msc_pkg::OFS_CTRL0: begin
				rd_val[msc_pkg::CTRL0_MODE_LSB +: 3] = mode;
				rd_val[msc_pkg::CTRL0_INTERP_BIT] = interp_en;
			end
			msc_pkg::OFS_RX_PHASE: rd_val[15:0] = rx_phase;
			msc_pkg::OFS_TX_PHASE: rd_val[15:0] = tx_phase;
			msc_pkg::OFS_STATUS: begin
				rd_val[msc_pkg::CTRL0_MODE_LSB +: 3] = mode;
				rd_val[msc_pkg::STAT_BUSY_BIT] = (seq != msc_pkg::SEQ_RUN);
				rd_val[msc_pkg::STAT_INTERP_BIT] = interp_act;
				rd_val[msc_pkg::STAT_BADMODE_BIT] = bad_mode;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q <= 8'h00;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else if (ce_i) begin
			wr_pend <= next_wr_pend;
			rd_pend <= next_rd_pend;
			addr_q <= next_addr_q;
			hrdata_o <= next_hrdata;
			hreadyout_o <= next_hreadyout;
			hresp_o <= 1'b0;
		end
	end

	// ==========================================================
	// Write decode and mode classification
	assign wr_ctrl0 = wr_pend && (addr_q == msc_pkg::OFS_CTRL0);
	assign wr_rx_ph = wr_pend && (addr_q == msc_pkg::OFS_RX_PHASE);
	assign wr_tx_ph = wr_pend && (addr_q == msc_pkg::OFS_TX_PHASE);
	assign wr_status = wr_pend && (addr_q == msc_pkg::OFS_STATUS);
	assign wr_code = hwdata_i[msc_pkg::CTRL0_MODE_LSB +: 3];
	assign code_ok = wr_code[2] || (wr_code == msc_pkg::MODE_ASYNC_FB);
	assign mode_async = (mode == msc_pkg::MODE_ASYNC_FB) ||
		(mode == msc_pkg::MODE_ASYNC_TERMINAL_SYNC_IN);
	assign mode_v32sync = (mode == msc_pkg::MODE_V32_TERMINAL_SYNC_IN) ||
		(mode == msc_pkg::MODE_V32_INT);
	// Receive phase is adjustable in every mode, transmit only in 000 and 101
	assign rx_adj_go = wr_rx_ph && (seq == msc_pkg::SEQ_RUN);
	assign tx_adj_go = wr_tx_ph && (seq == msc_pkg::SEQ_RUN) &&
		((mode == msc_pkg::MODE_ASYNC_FB) || (mode == msc_pkg::MODE_V32_INT));
	assign interp_act = interp_en && mode_v32sync && (seq == msc_pkg::SEQ_RUN);

	// ==========================================================
	// Mode register, phase registers and entry sequence
	always_comb begin
		next_mode = mode;
		next_seq = seq;
		next_interp_en = interp_en;
		next_bad_mode = bad_mode;
		next_rx_phase = rx_phase;
		next_tx_phase = tx_phase;
		// Sequence advances one step per cycle
		unique case (seq)
			msc_pkg::SEQ_SRST: next_seq = msc_pkg::SEQ_LOCK;
			msc_pkg::SEQ_LOCK: next_seq = msc_pkg::SEQ_RUN;
			msc_pkg::SEQ_RUN: next_seq = msc_pkg::SEQ_RUN;
			default: next_seq = msc_pkg::SEQ_RUN;
		endcase
		// Clear of the sticky flag loses to a refused write in the same cycle
		if (wr_status && hwdata_i[msc_pkg::STAT_BADMODE_BIT]) begin
			next_bad_mode = 1'b0;
		end
		if (wr_ctrl0) begin
			if (code_ok) begin
				next_mode = msc_pkg::msc_mode_e'(wr_code);
				next_interp_en = hwdata_i[msc_pkg::CTRL0_INTERP_BIT];
				if (wr_code != mode) begin
					if ((wr_code == msc_pkg::MODE_V32_TERMINAL_SYNC_IN ||
						wr_code == msc_pkg::MODE_V32_INT) && mode_async) begin
						next_seq = msc_pkg::SEQ_SRST;
					end else if (wr_code == msc_pkg::MODE_V32_TERMINAL_SYNC_IN ||
						wr_code == msc_pkg::MODE_V32_INT) begin
						next_seq = msc_pkg::SEQ_LOCK;
					end else begin
						next_seq = msc_pkg::SEQ_RUN;
					end
				end
			end else begin
				next_bad_mode = 1'b1;
			end
		end
		if (wr_rx_ph) begin
			next_rx_phase = hwdata_i[15:0];
		end
		if (wr_tx_ph) begin
			next_tx_phase = hwdata_i[15:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mode <= msc_pkg::msc_mode_e'(msc_pkg::RST_MODE);
			seq <= msc_pkg::SEQ_RUN;
			interp_en <= msc_pkg::RST_INTERP;
			bad_mode <= 1'b0;
			rx_phase <= msc_pkg::RST_PHASE;
			tx_phase <= msc_pkg::RST_PHASE;
		end else if (ce_i) begin
			mode <= next_mode;
			seq <= next_seq;
			interp_en <= next_interp_en;
			bad_mode <= next_bad_mode;
			rx_phase <= next_rx_phase;
			tx_phase <= next_tx_phase;
		end
	end

	// ==========================================================
	// Terminal sync pin: two flops, then a third for edge detection
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ts_meta <= 1'b0;
			ts_sync <= 1'b0;
			ts_prev <= 1'b0;
		end else if (ce_i) begin
			ts_meta <= terminal_sync_in_i;
			ts_sync <= ts_meta;
			ts_prev <= ts_sync;
		end
	end

	assign ts_edge = ts_sync && !ts_prev;

	// ==========================================================
	// Generator steering. Tracking is a hard restart on each sync edge;
	// it trades smooth slewing for a lock that completes in one period.
	always_comb begin
		tx_ctl = '0;
		rx_ctl = '0;
		tx_ctl.load_cnt = rx_cnt;
		rx_ctl.load_cnt = tx_cnt;
		rx_ctl.adj_valid = rx_adj_go;
		rx_ctl.adj = hwdata_i[15:0];
		tx_ctl.adj_valid = tx_adj_go;
		tx_ctl.adj = hwdata_i[15:0];
		unique case (mode)
			msc_pkg::MODE_ASYNC_FB: begin
				// Both sides free running, no locking at all
			end
			msc_pkg::MODE_ASYNC_TERMINAL_SYNC_IN: begin
				tx_ctl.restart = ts_edge;
			end
			msc_pkg::MODE_V32_TERMINAL_SYNC_IN: begin
				rx_ctl.load = (seq == msc_pkg::SEQ_LOCK);
				tx_ctl.restart = ts_edge && (seq == msc_pkg::SEQ_RUN);
			end
			msc_pkg::MODE_V32_INT: begin
				rx_ctl.load = (seq == msc_pkg::SEQ_LOCK);
			end
			msc_pkg::MODE_V32_LOOP: begin
				// Transmit copies receive each cycle and takes its shift too
				tx_ctl.load = 1'b1;
				tx_ctl.adj_valid = rx_adj_go;
				tx_ctl.adj = hwdata_i[15:0];
			end
			default: begin
				// Illegal code cannot be stored; leave both free
			end
		endcase
		// Soft reset puts both counter sets back to zero together
		if (seq == msc_pkg::SEQ_SRST) begin
			tx_ctl.restart = 1'b1;
			rx_ctl.restart = 1'b1;
		end
	end

	// Transmit strobe with its bit and baud clocks
	msc_strobe_gen #(
		.CONV_P(CONV_P),
		.BIT_P(BIT_P),
		.BAUD_P(BAUD_P)
	) u_tx_gen (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.ctl_i(tx_ctl),
		.cnt_o(tx_cnt),
		.out_o(tx_out)
	);

	// Receive strobe with its bit and baud clocks
	msc_strobe_gen #(
		.CONV_P(CONV_P),
		.BIT_P(BIT_P),
		.BAUD_P(BAUD_P)
	) u_rx_gen (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.ctl_i(rx_ctl),
		.cnt_o(rx_cnt),
		.out_o(rx_out)
	);

	// ==========================================================
	// Output stage: one register for every pin so all strobes keep
	// the same latency relative to each other.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_conv_strobe_o <= 1'b0;
			rx_conv_strobe_o <= 1'b0;
			tx_bit_clock_o <= 1'b0;
			tx_baud_clock_o <= 1'b0;
			rx_bit_clock_o <= 1'b0;
			rx_baud_clock_o <= 1'b0;
			adc_conv_o <= 1'b0;
			dac_conv_o <= 1'b0;
			interp_load_o <= 1'b0;
			interp_out_o <= 1'b0;
		end else if (ce_i) begin
			tx_conv_strobe_o <= tx_out.strobe;
			rx_conv_strobe_o <= rx_out.strobe;
			tx_bit_clock_o <= tx_out.bitc;
			tx_baud_clock_o <= tx_out.baud;
			rx_bit_clock_o <= rx_out.bitc;
			rx_baud_clock_o <= rx_out.baud;
			adc_conv_o <= mode_async ? rx_out.strobe : tx_out.strobe;
			dac_conv_o <= tx_out.strobe;
			interp_load_o <= interp_act && tx_out.strobe;
			interp_out_o <= interp_act && rx_out.strobe;
		end
	end

endmodule

// *** verification/msc_props.sv ***
// Port-level concurrent checks for the sample clock mode select block
`timescale 1ns/100ps
module msc_props (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic tx_conv_strobe_o,
	input wire logic rx_conv_strobe_o,
	input wire logic tx_bit_clock_o,
	input wire logic tx_baud_clock_o,
	input wire logic rx_bit_clock_o,
	input wire logic rx_baud_clock_o,
	input wire logic adc_conv_o,
	input wire logic dac_conv_o,
	input wire logic interp_load_o,
	input wire logic interp_out_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Bus phases: a taken request and the wait state of a read
	sequence s_take;
		hsel_i && hready_i && htrans_i[1] && ce_i;
	endsequence
	sequence s_one_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_read_one_wait: assert property (s_take and !hwrite_i |=> s_one_wait)
		else $error("read did not take exactly one wait state");
	a_write_no_wait: assert property (s_take and hwrite_i |=> hreadyout_o)
		else $error("write data phase was stretched");
	a_resp_okay: assert property (!hresp_o)
		else $error("slave response was not OKAY");
	a_ce_freeze: assert property (!ce_i |=> $stable(tx_conv_strobe_o) &&
		$stable(rx_conv_strobe_o) && $stable(hreadyout_o))
		else $error("outputs moved while the clock enable was low");
	// ==========================================================
	// Converter timing and clock alignment
	a_dac_on_tx: assert property (dac_conv_o == tx_conv_strobe_o)
		else $error("DAC conversion not on transmit strobe");
	a_adc_on_strobe: assert property (adc_conv_o |-> rx_conv_strobe_o || tx_conv_strobe_o)
		else $error("ADC conversion away from any strobe");
	a_rx_clk_sync: assert property (rx_bit_clock_o || rx_baud_clock_o |-> rx_conv_strobe_o)
		else $error("receive bit or baud clock off the receive strobe");
	a_tx_clk_sync: assert property (tx_bit_clock_o || tx_baud_clock_o |-> tx_conv_strobe_o)
		else $error("transmit bit or baud clock off the transmit strobe");
	a_interp_load_tx: assert property (interp_load_o |-> tx_conv_strobe_o)
		else $error("interpolator input not on transmit strobe");
	a_interp_out_rx: assert property (interp_out_o |-> rx_conv_strobe_o)
		else $error("interpolator output not on receive strobe");
endmodule

bind msc_top msc_props u_props (.clk_sys_i, .rst_i, .ce_i, .hsel_i, .htrans_i, .hwrite_i,
	.hready_i, .hreadyout_o, .hresp_o, .tx_conv_strobe_o, .rx_conv_strobe_o, .tx_bit_clock_o,
	.tx_baud_clock_o, .rx_bit_clock_o, .rx_baud_clock_o, .adc_conv_o, .dac_conv_o,
	.interp_load_o, .interp_out_o);

// *** verification/msc_sync_src.sv ***
// Far-end terminal model that drives the terminal sync pin
`timescale 1ns/100ps
module msc_sync_src #(
	parameter int PERIOD = 100
) (
	input wire logic clk_sys_i,
	input wire logic en_i,
	output logic sync_o
);
	int cnt = 0;
	// One rising edge per period; the pin rests low while the terminal is silent
	always @(posedge clk_sys_i) begin
		cnt <= (!en_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
		sync_o <= en_i && (cnt < PERIOD / 4);
	end
endmodule

// *** verification/msc_tb_top.sv ***
// Self-checking testbench for the sample clock mode select block
`timescale 1ns/100ps
module msc_tb_top;
	localparam int CP = 12;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, sync_en = 1'b0;
	logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o, d;
	logic [1:0] htrans_i = 2'b00;
	logic ce = 1'b1, c1, c2;
	logic [2:0] pm = 3'b000;
	logic hreadyout_o, hresp_o, sync, txs, rxs, adc, il, io;
	int errors = 0, compares = 0, seed = 88, g1, g2, v;
	logic [2:0] modes [7] = '{3'b000, 3'b111, 3'b100, 3'b101, 3'b110, 3'b000, 3'b101};
	msc_sync_src #(.PERIOD(100)) u_sync (.clk_sys_i(clk_sys_i), .en_i(sync_en), .sync_o(sync));
	msc_top #(.CONV_P(CP), .BIT_P(24), .BAUD_P(48)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ce_i(ce), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .terminal_sync_in_i(sync),
		.tx_conv_strobe_o(txs), .rx_conv_strobe_o(rxs), .tx_bit_clock_o(), .tx_baud_clock_o(),
		.rx_bit_clock_o(), .rx_baud_clock_o(), .adc_conv_o(adc), .dac_conv_o(), .interp_load_o(il),
		.interp_out_o(io));
	// ==========================================================
	// Clock, watchdog and verdict
	// One fixed clock: the block supports a single master rate only
	initial forever #10 clk_sys_i = ~clk_sys_i;
	initial begin
		#(60000 * 20);
		errors++;
		complete_run();
	end
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// ==========================================================
	// Expectations worked out from the mode table
	function automatic logic adc_on_rx(input logic [2:0] m);
		return m == 3'b000 || m == 3'b111;
	endfunction
	function automatic logic interp_on(input logic [2:0] m, input logic b9);
		return b9 && m[2:1] == 2'b10;
	endfunction
	// Entering 100 or 101 from an async mode is still busy at the next read
	function automatic logic entry_busy(input logic [2:0] p, input logic [2:0] m);
		return m[2:1] == 2'b10 && (p == 3'b000 || p == 3'b111);
	endfunction
	// ==========================================================
	// Bus master: waits for hready at each phase, never assumes a count
	task automatic bus_edge();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 40);
		check(n < 40, "bus hang");
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel_i <= 1'b1;
		haddr_i <= {24'h00_0000, a};
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		bus_edge();
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= wd;
		bus_edge();
		d = hrdata_o;
	endtask
	// Cycles from a transmit strobe to the next receive strobe
	task automatic gap(output int g);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (txs !== 1'b1 && n < 4 * CP);
		g = 0;
		while (rxs !== 1'b1 && g < 2 * CP) begin
			@(posedge clk_sys_i);
			g++;
		end
	endtask
	// Cycles from a transmit strobe, across a receive phase write, to the next one
	task automatic shift_span(input int pv, output int n);
		time t0;
		n = 0;
		repeat (2) @(posedge clk_sys_i);
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (txs !== 1'b1 && n < 4 * CP);
		t0 = $time;
		ahb(1, msc_pkg::OFS_RX_PHASE, pv);
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (txs !== 1'b1 && n < 4 * CP);
		n = int'(($time - t0) / 20);
	endtask
	// Watches converter and interpolator pulses for five strobe periods
	task automatic watch(input logic [2:0] m, input logic b9);
		int bad, ld, lp;
		bad = 0;
		ld = 0;
		lp = 0;
		repeat (5 * CP) begin
			@(posedge clk_sys_i);
			if (adc !== (adc_on_rx(m) ? rxs : txs)) bad++;
			if (il === 1'b1 || io === 1'b1) ld++;
			if (m == 3'b110 && txs !== rxs) lp++;
		end
		check(bad == 0, "converter timing source");
		check((ld > 0) === interp_on(m, b9), "interpolator activity");
		check(lp == 0, "loopback strobes apart");
	endtask
	// Transmit strobe lands exactly four edges after a terminal sync edge is seen
	task automatic sync_hit(output logic hit);
		int k;
		hit = 1'b0;
		k = 0;
		while (sync !== 1'b0 && k < 300) begin
			@(posedge clk_sys_i);
			k++;
		end
		while (sync !== 1'b1 && k < 300) begin
			@(posedge clk_sys_i);
			k++;
		end
		hit = (k < 300);
		for (k = 1; k <= 6; k++) begin
			@(posedge clk_sys_i);
			// Restart pulse on the fourth edge, then a fresh period begins
			if (k >= 4 && txs !== (k == 4)) hit = 1'b0;
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		logic b9, h;
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		ahb(0, msc_pkg::OFS_CTRL0, 0);
		check(d === 32'h0000_0000, "control reset value");
		ahb(0, 8'h30, 0);
		check(d === 32'h0000_0000, "unmapped read");
		$display("test reset done");
		foreach (modes[i]) begin
			b9 = $random(seed);
			ahb(1, msc_pkg::OFS_CTRL0, {22'h00_0000, b9, 6'h00, modes[i]});
			ahb(0, msc_pkg::OFS_STATUS, 0);
			check(d[msc_pkg::STAT_BUSY_BIT] === entry_busy(pm, modes[i]), "entry busy");
			pm = modes[i];
			// The entry sequence is transient; let it finish before the flags
			repeat (4) @(posedge clk_sys_i);
			ahb(0, msc_pkg::OFS_STATUS, 0);
			check(d[2:0] === modes[i], "mode readback");
			check(d[msc_pkg::STAT_INTERP_BIT] === interp_on(modes[i], b9), "interp flag");
			watch(modes[i], b9);
		end
		$display("test mode sweep done");
		for (int m = 1; m <= 3; m++) begin
			ahb(1, msc_pkg::OFS_CTRL0, 32'h0000_0200 | m);
			ahb(0, msc_pkg::OFS_CTRL0, 0);
			check(d[2:0] === 3'b101 && d[9] === b9, "undefined mode kept out");
			ahb(0, msc_pkg::OFS_STATUS, 0);
			check(d[msc_pkg::STAT_BADMODE_BIT] === 1'b1, "undefined mode flag");
			ahb(1, msc_pkg::OFS_STATUS, 32'h0000_0020);
			ahb(0, msc_pkg::OFS_STATUS, 0);
			check(d[msc_pkg::STAT_BADMODE_BIT] === 1'b0, "flag clear");
		end
		$display("test undefined modes done");
		ahb(1, msc_pkg::OFS_CTRL0, 0);
		v = 1 + ({$random(seed)} % (CP - 1));
		gap(g1);
		ahb(1, msc_pkg::OFS_RX_PHASE, v);
		gap(g2);
		check(g2 == (g1 + v) % CP || g2 == (g1 + CP - v) % CP, "rx phase shift");
		ahb(1, msc_pkg::OFS_CTRL0, 32'h0000_0005);
		gap(g1);
		check(g1 == 0, "rx locked to tx");
		ahb(1, msc_pkg::OFS_TX_PHASE, v);
		gap(g2);
		check(g2 == v || g2 == CP - v, "tx phase shift");
		ahb(1, msc_pkg::OFS_CTRL0, 32'h0000_0007);
		gap(g1);
		ahb(1, msc_pkg::OFS_TX_PHASE, v);
		gap(g2);
		check(g2 == g1, "tx phase ignored");
		ahb(1, msc_pkg::OFS_CTRL0, 32'h0000_0006);
		shift_span(v, g1);
		check(g1 % CP == CP - v, "loopback tx takes rx shift");
		gap(g2);
		check(g2 == 0, "loopback shift");
		$display("test phase adjust done");
		sync_en <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (i == 0 || i == 3) ahb(1, msc_pkg::OFS_CTRL0, i == 0 ? 32'h7 : 32'h4);
			sync_hit(h);
			check(h, "tx strobe follows terminal sync");
		end
		sync_en <= 1'b0;
		$display("test terminal sync done");
		// Clock enable low must hold every output where it stands
		ce <= 1'b0;
		@(posedge clk_sys_i);
		c1 = txs;
		c2 = rxs;
		v = 0;
		repeat (3 * CP) begin
			@(posedge clk_sys_i);
			if (txs !== c1 || rxs !== c2 || hreadyout_o !== 1'b1) v++;
		end
		ce <= 1'b1;
		check(v == 0, "clock enable freeze");
		$display("test clock enable done");
		complete_run();
	end
endmodule
